// [core/psap_pkg.sv]
// Shared constants, register map and carrier types of the serial audio port.
package psap_pkg;

  // System clock and bit-clock timing.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned BIT_CLK_HALF_NS = 500;
  localparam int unsigned BIT_CLK_HALF_CYC =
    (BIT_CLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte addresses.
  localparam logic [31:0] ADDR_SRC_SEL = 32'h5000401c;
  localparam logic [31:0] ADDR_CTRL = 32'h50004100;
  localparam logic [31:0] ADDR_RX_FIRST = 32'h50004104;
  localparam logic [31:0] ADDR_RX_SECOND = 32'h50004108;
  localparam logic [31:0] ADDR_TX_FIRST = 32'h5000410c;
  localparam logic [31:0] ADDR_TX_SECOND = 32'h50004110;

  // Reset values and writable masks.
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_WR_MASK = 32'hfff1ffff;
  localparam logic [31:0] RX_RESET = 32'h00000000;
  localparam logic [31:0] TX_RESET = 32'hffffffff;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
  localparam int unsigned SRC_SEL_LSB = 3;
  localparam int unsigned SRC_SEL_W = 3;

  // Transmit source selector codes.
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_CONV = 3'h1;
  localparam logic [2:0] SRC_WORDS = 3'h2;

  // Frame geometry in bit periods, and FIFO depth in frames.
  localparam logic [11:0] FRAME_BITS = 12'h040;
  localparam logic [11:0] HALF_BITS = 12'h020;
  localparam logic [11:0] ONE_PERIOD = 12'h001;
  localparam int unsigned FIFO_DEPTH = 16;

  // Control word, most significant field first.
  typedef struct packed {
    logic [11:0] divider;
    logic [2:0] reserved;
    logic half_edge;
    logic [4:0] channel_delay;
    logic two_clk;
    logic fsc_invert;
    logic clk_invert;
    logic open_drain;
    logic fsc_align;
    logic [3:0] fsc_length;
    logic master;
    logic enable;
  } psap_ctrl_t;

  // One frame of eight channels: first word holds channels one to four.
  typedef struct packed {
    logic [31:0] first;
    logic [31:0] second;
  } psap_frame_t;

  typedef enum logic [1:0] {PS_IDLE, PS_SYNC, PS_RUN} psap_state_t;

endpackage : psap_pkg

// [core/psap_tick.sv]
// Enable-pulse divider that paces the generated bit clock.
`timescale 1ns/1ps
`default_nettype none
module psap_tick #(
  parameter int unsigned DIV = psap_pkg::BIT_CLK_HALF_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control and pulse.
  input wire logic run,
  output logic tick
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count + 16'h0001;
    next_tick = 1'b0;
    if (!run) begin
      next_count = 16'h0000;
    end else if (count == 16'(DIV - 1)) begin
      next_count = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule : psap_tick
`default_nettype wire

// [core/psap_fifo.sv]
// Frame FIFO between the rate-converter stream and the transmit serializer.
`timescale 1ns/1ps
`default_nettype none
module psap_fifo #(
  parameter int unsigned W = 64,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr, next_fill;
  logic next_in_ready, next_out_valid, push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Ready and valid are registered so the filling side sees a clean level.
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_fill = next_wr_ptr - next_rd_ptr;
    next_in_ready = next_fill != (AW + 1)'(DEPTH);
    next_out_valid = next_fill != '0;
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end
endmodule : psap_fifo
`default_nettype wire

// [core/psap_port.sv]
// Serial PCM audio port: registers, frame timing, serializer and deserializer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] As master, a frame lasts divider-field plus one bit-clock cycles.
// [R2] Software keeps the divider field at seven or more so a frame holds eight bits.
// [R3] Software picks an even frame length when two clocks per bit are used.
// [R4] Edge select clear sends all eight channels after the sync edge, set splits them 4 and 4.
// [R5] Channel data starts channel-delay times eight bit periods later than usual.
// [R6] Each data bit lasts one bit-clock cycle, or two when the two-clock option is set.
// [R7] Frame-sync inversion flips the polarity of the sync pin both ways.
// [R8] Clock inversion flips the bit-clock pin, swapping launch and sample edges.
// [R9] The data pin is push-pull, or open-drain driving low only when selected.
// [R10] Sync leads the first data bit by one period, or lines up with it when aligned.
// [R11] Sync lasts one bit period for length zero, else length times eight periods.
// [R12] Master mode makes bit clock and sync; slave mode follows the partner's.
// [R13] Nothing is transferred while the enable bit is low.
// [R14] Transmit data comes from nothing, the converter FIFO, or the two transmit words.
// [R15] Eight received channels are packed into the two receive words once per frame.
// [R16] Transmit words go out most significant bit first and reset to all ones.
module psap_port (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Register port.
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Rate-converter frame stream.
  input wire logic SRC_VALID,
  input wire psap_pkg::psap_frame_t SRC_DATA,
  output logic SRC_READY,
  // Bit-clock pin.
  input wire logic BIT_CLK_I,
  output logic BIT_CLK_O,
  output logic BIT_CLK_OE_N,
  // Frame-sync pin.
  input wire logic FRAME_SYNC_I,
  output logic FRAME_SYNC_O,
  output logic FRAME_SYNC_OE_N,
  // Serial data pins.
  input wire logic SER_DI,
  output logic SER_DO_O,
  output logic SER_DO_OE_N
);
  // Register state.
  psap_pkg::psap_ctrl_t ctrl, next_ctrl;
  logic [31:0] rx_first, rx_second, tx_first, tx_second;
  logic [31:0] next_rx_first, next_rx_second, next_tx_first, next_tx_second;
  logic [31:0] next_rdata;
  logic [2:0] src_sel, next_src_sel;

  // Pin synchronisers.
  logic clk_s1, clk_s2, clk_s3, fsc_s1, fsc_s2, fsc_s3, di_s1, di_s2;

  // Frame engine state.
  psap_pkg::psap_state_t state, next_state;
  logic ph, next_ph;
  logic [11:0] cyc, next_cyc, half_pos, next_half_pos;
  logic fsc_at_rise, next_fsc_at_rise;
  logic launch_pend, next_launch_pend;
  logic [63:0] tx_frame, next_tx_frame, rx_acc, next_rx_acc;

  // Pin output state.
  logic next_clk_o, next_clk_oe_n, next_fsc_o, next_fsc_oe_n, next_do_o, next_do_oe_n;

  // Derived timing terms.
  logic tick, run_tick, int_rise, int_fall, slave_clk, slave_clk_d, fsc_now;
  logic frame_start, launch_ok, sample_ok, bit_valid, valid1, valid2, fsc_act, tx_bit;
  logic [11:0] p, off, base2, d1, d2, lim1, fsc_periods;
  logic [5:0] idx;
  logic fifo_valid, fifo_pop;
  psap_pkg::psap_frame_t fifo_data;

  psap_tick #(
    .DIV(psap_pkg::BIT_CLK_HALF_CYC)
  ) u_tick (
    .clk(CLK),
    .rst(RST),
    .run(run_tick),
    .tick(tick)
  );

  psap_fifo #(
    .W($bits(psap_pkg::psap_frame_t)),
    .DEPTH(psap_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(SRC_VALID),
    .in_ready(SRC_READY),
    .in_data(SRC_DATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Register file.
  always_comb begin
    next_ctrl = ctrl;
    next_src_sel = src_sel;
    next_tx_first = tx_first;
    next_tx_second = tx_second;
    next_rx_first = rx_first;
    next_rx_second = rx_second;
    next_rdata = psap_pkg::READ_UNMAPPED;
    if (WR) begin
      case (ADDR)
        psap_pkg::ADDR_CTRL: next_ctrl = WDATA & psap_pkg::CTRL_WR_MASK;
        psap_pkg::ADDR_SRC_SEL: next_src_sel = WDATA[psap_pkg::SRC_SEL_LSB +: psap_pkg::SRC_SEL_W];
        psap_pkg::ADDR_TX_FIRST: next_tx_first = WDATA;
        psap_pkg::ADDR_TX_SECOND: next_tx_second = WDATA;
        default: next_ctrl = ctrl;
      endcase
    end
    if (RD) begin
      case (ADDR)
        psap_pkg::ADDR_CTRL: next_rdata = ctrl;
        psap_pkg::ADDR_SRC_SEL: next_rdata = 32'(src_sel) << psap_pkg::SRC_SEL_LSB;
        psap_pkg::ADDR_RX_FIRST: next_rdata = rx_first;
        psap_pkg::ADDR_RX_SECOND: next_rdata = rx_second;
        psap_pkg::ADDR_TX_FIRST: next_rdata = tx_first;
        psap_pkg::ADDR_TX_SECOND: next_rdata = tx_second;
        default: next_rdata = psap_pkg::READ_UNMAPPED;
      endcase
    end
    // A frame that completed hands its channels to software in one step.
    if (frame_start && state == psap_pkg::PS_RUN) begin
      next_rx_first = rx_acc[63:32]; // [R15]
      next_rx_second = rx_acc[31:0]; // [R15]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= psap_pkg::CTRL_RESET;
      src_sel <= psap_pkg::SRC_OFF;
      tx_first <= psap_pkg::TX_RESET; // [R16]
      tx_second <= psap_pkg::TX_RESET; // [R16]
      rx_first <= psap_pkg::RX_RESET;
      rx_second <= psap_pkg::RX_RESET;
      RDATA <= psap_pkg::READ_UNMAPPED;
    end else begin
      ctrl <= next_ctrl;
      src_sel <= next_src_sel;
      tx_first <= next_tx_first;
      tx_second <= next_tx_second;
      rx_first <= next_rx_first;
      rx_second <= next_rx_second;
      RDATA <= next_rdata;
    end
  end

  // The first stage of each synchroniser feeds only its second stage.
  always_ff @(posedge CLK) begin
    if (RST) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      fsc_s1 <= 1'b0;
      fsc_s2 <= 1'b0;
      fsc_s3 <= 1'b0;
      di_s1 <= 1'b1;
      di_s2 <= 1'b1;
    end else begin
      clk_s1 <= BIT_CLK_I;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      fsc_s1 <= FRAME_SYNC_I;
      fsc_s2 <= fsc_s1;
      fsc_s3 <= fsc_s2;
      di_s1 <= SER_DI;
      di_s2 <= di_s1;
    end
  end

  // Internal clock edges: launch on the internal rise, sample on the internal fall.
  assign run_tick = ctrl.enable && ctrl.master; // [R12] [R13]
  assign slave_clk = clk_s2 ^ ctrl.clk_invert; // [R8]
  assign slave_clk_d = clk_s3 ^ ctrl.clk_invert; // [R8]
  assign fsc_now = fsc_s2 ^ ctrl.fsc_invert; // [R7]
  assign int_rise = ctrl.enable && (ctrl.master ? (tick && !ph) : (slave_clk && !slave_clk_d));
  assign int_fall = ctrl.enable && (ctrl.master ? (tick && ph) : (!slave_clk && slave_clk_d));

  // Master frames wrap on the divider; slave frames restart on the sync edge.
  assign frame_start = int_rise && (ctrl.master ?
    (state == psap_pkg::PS_SYNC || cyc == ctrl.divider) : // [R1] [R12]
    (fsc_now && !fsc_at_rise)); // [R12]

  // Bit period index and data window within the frame.
  assign p = ctrl.two_clk ? {1'b0, cyc[11:1]} : cyc; // [R6]
  assign launch_ok = !ctrl.two_clk || !cyc[0]; // [R6]
  assign sample_ok = !ctrl.two_clk || cyc[0]; // [R6]
  assign off = {4'h0, ctrl.channel_delay, 3'h0} + {11'h000, !ctrl.fsc_align}; // [R5] [R10]
  assign fsc_periods = (ctrl.fsc_length == 4'h0) ? psap_pkg::ONE_PERIOD :
    {5'h00, ctrl.fsc_length, 3'h0}; // [R11]
  assign lim1 = ctrl.half_edge ? psap_pkg::HALF_BITS : psap_pkg::FRAME_BITS; // [R4]
  assign d1 = p - off;
  assign valid1 = (p >= off) && (d1 < lim1); // [R4] [R5]
  // The second half starts after the opposite sync edge with the same delay.
  assign base2 = (ctrl.master ? fsc_periods : half_pos) + off; // [R4]
  assign d2 = p - base2;
  assign valid2 = ctrl.half_edge && (p >= base2) && (d2 < psap_pkg::HALF_BITS); // [R4]
  assign bit_valid = valid1 || valid2;
  assign idx = valid1 ? d1[5:0] : {1'b1, d2[4:0]};
  assign tx_bit = tx_frame[~idx]; // [R16]
  assign fsc_act = p < fsc_periods; // [R11]
  assign fifo_pop = frame_start && src_sel == psap_pkg::SRC_CONV; // [R14]

  // Frame engine.
  always_comb begin
    next_state = state;
    next_ph = ph;
    next_cyc = cyc;
    next_half_pos = half_pos;
    next_fsc_at_rise = fsc_at_rise;
    next_launch_pend = 1'b0;
    next_tx_frame = tx_frame;
    next_rx_acc = rx_acc;
    case (state)
      psap_pkg::PS_IDLE: begin
        if (ctrl.enable) begin
          next_state = psap_pkg::PS_SYNC;
        end
      end
      psap_pkg::PS_SYNC, psap_pkg::PS_RUN: begin
        if (frame_start) begin
          next_state = psap_pkg::PS_RUN;
        end
      end
      default: next_state = psap_pkg::PS_IDLE;
    endcase
    if (ctrl.master && tick) begin
      next_ph = !ph; // [R12]
    end
    if (int_rise) begin
      next_fsc_at_rise = fsc_now;
      next_launch_pend = state != psap_pkg::PS_IDLE;
      if (!ctrl.master && !fsc_now && fsc_at_rise) begin
        next_half_pos = ctrl.two_clk ? {1'b0, cyc[11:1]} : cyc; // [R4]
      end
      if (frame_start) begin
        next_cyc = '0;
        next_rx_acc = '0;
        case (src_sel) // [R14]
          psap_pkg::SRC_CONV: next_tx_frame = fifo_valid ? fifo_data : {2{psap_pkg::TX_RESET}};
          psap_pkg::SRC_WORDS: next_tx_frame = {tx_first, tx_second};
          default: next_tx_frame = {2{psap_pkg::TX_RESET}};
        endcase
      end else if (state == psap_pkg::PS_RUN) begin
        next_cyc = cyc + 12'h001;
      end
    end
    if (int_fall && state == psap_pkg::PS_RUN && sample_ok && bit_valid) begin
      next_rx_acc[~idx] = di_s2; // [R15]
    end
    // Disabling parks the engine so that a later enable starts a clean frame.
    if (!ctrl.enable) begin
      next_state = psap_pkg::PS_IDLE; // [R13]
      next_ph = 1'b0;
      next_cyc = '0;
      next_half_pos = '0;
      next_fsc_at_rise = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= psap_pkg::PS_IDLE;
      ph <= 1'b0;
      cyc <= '0;
      half_pos <= '0;
      fsc_at_rise <= 1'b0;
      launch_pend <= 1'b0;
      tx_frame <= {2{psap_pkg::TX_RESET}};
      rx_acc <= '0;
    end else begin
      state <= next_state;
      ph <= next_ph;
      cyc <= next_cyc;
      half_pos <= next_half_pos;
      fsc_at_rise <= next_fsc_at_rise;
      launch_pend <= next_launch_pend;
      tx_frame <= next_tx_frame;
      rx_acc <= next_rx_acc;
    end
  end

  // Pin drivers; enables are active low and released outside the active role.
  always_comb begin
    next_clk_o = ph ^ ctrl.clk_invert; // [R8]
    next_clk_oe_n = !(ctrl.enable && ctrl.master); // [R12] [R13]
    next_fsc_oe_n = !(ctrl.enable && ctrl.master); // [R12]
    // Until the first launch the sync sits inactive and a push-pull line idles high.
    next_fsc_o = (state == psap_pkg::PS_IDLE) ? ctrl.fsc_invert : FRAME_SYNC_O; // [R7]
    next_do_o = !ctrl.open_drain && (SER_DO_OE_N || SER_DO_O); // [R9]
    next_do_oe_n = ctrl.open_drain && (SER_DO_OE_N || SER_DO_O); // [R9]
    if (!ctrl.enable) begin
      next_fsc_o = ctrl.fsc_invert; // [R7]
      next_do_o = 1'b0;
      next_do_oe_n = 1'b1; // [R13]
    end else if (launch_pend) begin
      next_fsc_o = (state == psap_pkg::PS_RUN && fsc_act) ^ ctrl.fsc_invert; // [R7] [R10]
      if (launch_ok) begin
        // Outside the data window the line idles high.
        if (ctrl.open_drain) begin
          next_do_o = 1'b0; // [R9]
          next_do_oe_n = !bit_valid || tx_bit; // [R9]
        end else begin
          next_do_o = !bit_valid || tx_bit; // [R9] [R16]
          next_do_oe_n = 1'b0; // [R9]
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      BIT_CLK_O <= 1'b0;
      BIT_CLK_OE_N <= 1'b1;
      FRAME_SYNC_O <= 1'b0;
      FRAME_SYNC_OE_N <= 1'b1;
      SER_DO_O <= 1'b0;
      SER_DO_OE_N <= 1'b1;
    end else begin
      BIT_CLK_O <= next_clk_o;
      BIT_CLK_OE_N <= next_clk_oe_n;
      FRAME_SYNC_O <= next_fsc_o;
      FRAME_SYNC_OE_N <= next_fsc_oe_n;
      SER_DO_O <= next_do_o;
      SER_DO_OE_N <= next_do_oe_n;
    end
  end
endmodule : psap_port
`default_nettype wire

// [dv/psap_port_properties.sv]
// Concurrent checks on the register port and pins of the serial audio port.
`timescale 1ns/1ps
`default_nettype none
module psap_port_properties (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // Register port.
  input wire logic [31:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Pin outputs.
  input wire logic BIT_CLK_O,
  input wire logic BIT_CLK_OE_N,
  input wire logic FRAME_SYNC_O,
  input wire logic FRAME_SYNC_OE_N,
  input wire logic SER_DO_O,
  input wire logic SER_DO_OE_N
);
  psap_pkg::psap_ctrl_t ctrl, ctrl_d;
  logic wr_d, act, act_d, bk_d, fs_seen, bk_seen, stable, quiet, run_m;
  int unsigned wcnt, pcnt, bcnt, bit_cyc, sync_len;

  // Pins lag the control word, so edges are judged only once two cycles clear of a write.
  assign quiet = !WR && !wr_d;
  assign stable = (ctrl == ctrl_d);
  assign run_m = ctrl.enable && ctrl.master;
  assign act = FRAME_SYNC_O ^ ctrl.fsc_invert;
  assign bit_cyc = (ctrl.two_clk ? 4 : 2) * psap_pkg::BIT_CLK_HALF_CYC;
  assign sync_len = (ctrl.fsc_length == 4'h0) ? 1 : 8 * ctrl.fsc_length;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= '0;
      ctrl_d <= '0;
      wr_d <= 1'b0;
      act_d <= 1'b0;
      bk_d <= 1'b0;
      fs_seen <= 1'b0;
      bk_seen <= 1'b0;
      wcnt <= 0;
      pcnt <= 0;
      bcnt <= 0;
    end else begin
      if (WR && ADDR == psap_pkg::ADDR_CTRL) begin
        ctrl <= WDATA & psap_pkg::CTRL_WR_MASK;
      end
      ctrl_d <= ctrl;
      wr_d <= WR;
      act_d <= act;
      bk_d <= BIT_CLK_O;
      wcnt <= act ? wcnt + 1 : 0;
      pcnt <= (act && !act_d) ? 1 : pcnt + 1;
      bcnt <= (BIT_CLK_O != bk_d) ? 1 : bcnt + 1;
      fs_seen <= quiet && (fs_seen || (act && !act_d));
      bk_seen <= quiet && (bk_seen || (BIT_CLK_O != bk_d));
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_ctrl_readback: assert property (
    $past(RD) && $past(ADDR) == psap_pkg::ADDR_CTRL |-> RDATA == ctrl)
    else $error("control read-back differs from the last write");
  chk_idle_released: assert property (
    !ctrl.enable && stable |-> BIT_CLK_OE_N && FRAME_SYNC_OE_N && SER_DO_OE_N)
    else $error("a pin is driven while the port is disabled");
  chk_master_drives: assert property (
    run_m && stable |-> !BIT_CLK_OE_N && !FRAME_SYNC_OE_N)
    else $error("master does not drive bit clock and sync");
  chk_slave_listens: assert property (
    ctrl.enable && !ctrl.master && stable |=> BIT_CLK_OE_N && FRAME_SYNC_OE_N)
    else $error("slave drives bit clock or sync");
  chk_push_pull: assert property (
    ctrl.enable && !ctrl.open_drain && stable |-> !SER_DO_OE_N)
    else $error("push-pull data pin not driven");
  chk_open_drain: assert property (
    ctrl.enable && ctrl.open_drain && stable |-> SER_DO_O == 1'b0)
    else $error("open-drain data pin drives high");
  chk_clk_half: assert property (
    run_m && bk_seen && BIT_CLK_O != bk_d |-> bcnt == psap_pkg::BIT_CLK_HALF_CYC)
    else $error("generated bit clock half period is wrong");
  chk_sync_width: assert property (
    run_m && fs_seen && !act && act_d |-> wcnt == sync_len * bit_cyc)
    else $error("frame sync width is wrong");
  chk_frame_period: assert property (
    run_m && fs_seen && act && !act_d |-> pcnt == (ctrl.divider + 1) * 40)
    else $error("frame period is wrong");
endmodule : psap_port_properties

bind psap_port psap_port_properties u_props (.CLK, .RST, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .BIT_CLK_O, .BIT_CLK_OE_N, .FRAME_SYNC_O, .FRAME_SYNC_OE_N, .SER_DO_O,
  .SER_DO_OE_N);
`default_nettype wire

// [dv/psap_codec_model.sv]
// Behavioural codec that clocks the port as its master-side partner.
`timescale 1ns/1ps
`default_nettype none
module psap_codec_model (
  // Pins towards the port.
  output logic bclk,
  output logic fsync,
  output logic sdata,
  input wire logic sdo_o,
  input wire logic sdo_oe_n
);
  logic [63:0] heard;
  logic line;

  // The data line has a pull-up, so a released open-drain pin reads high.
  assign line = sdo_oe_n ? 1'b1 : sdo_o;

  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    sdata = 1'b1;
    heard = '0;
  end

  // The clock stands still outside frames; data launch on rise, capture on fall.
  task automatic run_frames(input int n, input logic [63:0] tx);
    // Pin edges are kept clear of the system clock edge to avoid a sampling race.
    #7;
    for (int f = 0; f < n; f++) begin
      for (int p = 0; p < 66; p++) begin
        fsync = (p == 0);
        #500;
        bclk = 1'b1;
        sdata = (p >= 1 && p <= 64) ? tx[64-p] : ~sdata;
        #500;
        bclk = 1'b0;
        if (p >= 1 && p <= 64) begin
          heard[64-p] = line;
        end
      end
    end
    fsync = 1'b0;
  endtask : run_frames
endmodule : psap_codec_model
`default_nettype wire

// [dv/psap_port_tb.sv]
// Self-checking bench of the serial audio port against a codec partner.
`timescale 1ns/1ps
`default_nettype none
module psap_port_tb;
  logic clk, rst, wr_s, rd_s, src_valid, src_ready;
  logic [31:0] addr, wdata, rdata;
  psap_pkg::psap_frame_t src_data;
  logic bclk_o, bclk_oe_n, fs_o, fs_oe_n, sdo_o, sdo_oe_n;
  logic m_bclk, m_fs, m_sd, bclk_w, fs_w, sdo_w;
  int err_total, n_compared;

  assign bclk_w = bclk_oe_n ? m_bclk : bclk_o;
  assign fs_w = fs_oe_n ? m_fs : fs_o;
  assign sdo_w = sdo_oe_n ? 1'b1 : sdo_o;

  psap_port u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .SRC_VALID(src_valid), .SRC_DATA(src_data),
    .SRC_READY(src_ready), .BIT_CLK_I(bclk_w), .BIT_CLK_O(bclk_o),
    .BIT_CLK_OE_N(bclk_oe_n), .FRAME_SYNC_I(fs_w), .FRAME_SYNC_O(fs_o),
    .FRAME_SYNC_OE_N(fs_oe_n), .SER_DI(m_sd), .SER_DO_O(sdo_o), .SER_DO_OE_N(sdo_oe_n));
  psap_codec_model u_codec (.bclk(m_bclk), .fsync(m_fs), .sdata(m_sd), .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rdc

  // Counts cycles until the sync, seen through its polarity, reaches the wanted level.
  task automatic wait_act(input logic v, input logic inv, output int n);
    n = 0;
    while (((fs_o ^ inv) !== v) && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6000) begin
      err_total++;
      close_out();
    end
  endtask : wait_act

  task automatic count_low(input int n, output int z);
    z = 0;
    repeat (n) begin
      @(negedge clk);
      if (sdo_w === 1'b0) z++;
    end
  endtask : count_low

  task automatic t_regs();
    rdc(psap_pkg::ADDR_CTRL, 32'h0);
    rdc(psap_pkg::ADDR_RX_FIRST, 32'h0);
    rdc(psap_pkg::ADDR_RX_SECOND, 32'h0);
    rdc(psap_pkg::ADDR_TX_FIRST, 32'hffffffff);
    rdc(psap_pkg::ADDR_TX_SECOND, 32'hffffffff);
    rdc(32'h50004114, 32'h0);
    wr(psap_pkg::ADDR_CTRL, 32'hffffffff);
    rdc(psap_pkg::ADDR_CTRL, 32'hfff1ffff);
    wr(psap_pkg::ADDR_CTRL, 32'h0);
    wr(psap_pkg::ADDR_RX_FIRST, 32'h12345678);
    rdc(psap_pkg::ADDR_RX_FIRST, 32'h0);
    wr(psap_pkg::ADDR_SRC_SEL, 32'hffffffff);
    rdc(psap_pkg::ADDR_SRC_SEL, 32'h38);
  endtask : t_regs

  task automatic t_master_sync();
    int n, w, q;
    for (int c = 0; c < 2; c++) begin
      wr(psap_pkg::ADDR_CTRL, 32'h0);
      repeat (3) @(negedge clk);
      chk({29'h0, bclk_oe_n, fs_oe_n, sdo_oe_n}, 32'h7);
      wr(psap_pkg::ADDR_CTRL, {12'h03f, 9'h0, c[0], c[0], 3'h0, 4'h1, 2'h3});
      wait_act(1'b0, c[0], n);
      wait_act(1'b1, c[0], n);
      wait_act(1'b0, c[0], w);
      wait_act(1'b1, c[0], q);
      chk(w, c[0] ? 32'd640 : 32'd320);
      chk(w + q, 32'd2560);
      chk({31'h0, bclk_oe_n}, 32'h0);
    end
  endtask : t_master_sync

  task automatic t_slave_loop();
    for (int c = 0; c < 2; c++) begin
      wr(psap_pkg::ADDR_CTRL, 32'h0);
      wr(psap_pkg::ADDR_TX_FIRST, 32'h8c3a5f01);
      wr(psap_pkg::ADDR_TX_SECOND, 32'h7e12c4b9);
      wr(psap_pkg::ADDR_SRC_SEL, 32'h10);
      wr(psap_pkg::ADDR_CTRL, {24'h0, c[0], 7'h01});
      u_codec.run_frames(3, 64'h13579bdf2468ace1);
      chk(u_codec.heard[63:32], 32'h8c3a5f01);
      chk(u_codec.heard[31:0], 32'h7e12c4b9);
      rdc(psap_pkg::ADDR_RX_FIRST, 32'h13579bdf);
      rdc(psap_pkg::ADDR_RX_SECOND, 32'h2468ace1);
    end
  endtask : t_slave_loop

  task automatic t_fifo();
    int n, z;
    wr(psap_pkg::ADDR_CTRL, 32'h0);
    wr(psap_pkg::ADDR_SRC_SEL, 32'h08);
    n = 0;
    src_valid <= 1'b1;
    while (n < 40) begin
      @(negedge clk);
      if (!src_ready) break;
      n++;
      @(posedge clk);
    end
    @(posedge clk);
    src_valid <= 1'b0;
    chk(n, psap_pkg::FIFO_DEPTH);
    wr(psap_pkg::ADDR_CTRL, {12'h007, 20'h00003});
    count_low(5600, z);
    chk({31'h0, z != 0}, 32'h1);
    chk({31'h0, src_ready}, 32'h1);
    count_low(640, z);
    chk(z, 32'h0);
    wr(psap_pkg::ADDR_SRC_SEL, 32'h0);
    count_low(640, z);
    chk(z, 32'h0);
    wr(psap_pkg::ADDR_CTRL, 32'h0);
  endtask : t_fifo

  initial begin
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = '0;
    wdata = '0;
    src_valid = 1'b0;
    src_data = {32'h0f0f0f0f, 32'h00ff00ff};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_master_sync();
    t_slave_loop();
    t_fifo();
    close_out();
  end
endmodule : psap_port_tb
`default_nettype wire
